/* verilog/psb_defines.svh */
// Purpose: constants for the pseudo-static memory bus front end
// Assumes: ref_clk at 20 MHz, one memory word is 16 bits
// Notes:   register offsets are byte addresses on the plain register port
//
// What this block does
// - refresh opportunity: select high at a clock edge or over 15 ns; the block counts only a select high sampled at a clock edge
// - read row crossing: wait asserted at most twice latency code clocks
// - latency code sits in config bits 13:11; code two means three clocks
// - write row end: wait held between one and two latency codes
// - select high or address valid low on write start-of-row aborts, drops data
`ifndef PSB_DEFINES_SVH
`define PSB_DEFINES_SVH

`define PSB_REG_CFG       4'h0
`define PSB_REG_STAT      4'h4
`define PSB_CFG_RESET     16'h9900
`define PSB_CFG_ASYNC     15
`define PSB_CFG_LC_HI     13
`define PSB_CFG_LC_LO     11
`define PSB_STAT_INIT     0
`define PSB_STAT_REFOVR   1
`define PSB_STAT_WELONG   2
`define PSB_STAT_ABORT    3

`define PSB_CLK_NS        50
`define PSB_CEM_US        8
`define PSB_CEM_CYC       ((`PSB_CEM_US * 1000) / `PSB_CLK_NS)
`define PSB_PU_US         150
`define PSB_PU_CYC        ((`PSB_PU_US * 1000) / `PSB_CLK_NS)
`define PSB_REFOP_NS      15
`define PSB_REFOP_CYC     ((`PSB_REFOP_NS + `PSB_CLK_NS - 1) / `PSB_CLK_NS)

`define PSB_MEM_AW        8
`define PSB_ROW_AW        7
`define PSB_FIFO_DEPTH    8

`endif

/* verilog/psb_pkg.sv */
// Purpose: shared types of the memory bus front end
// Assumes: nothing beyond the defines header
// Notes:   state values carry no fixed codes
package psb_pkg;
  typedef enum {PSB_IDLE, PSB_LAT, PSB_DATA, PSB_ROWWAIT} psb_state_t;
  typedef logic [15:0] psb_word_t;
endpackage

/* verilog/psb_core.sv */
// Purpose: device-side logic of a pseudo-static memory bus with bursts
// Assumes: pins sampled on ref_clk, which is also the burst clock
// Notes:   small array stands in for the full 1M x 16 cell array
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "psb_defines.svh"

////////////////////////////////////////////////////////////////////////////
module psb_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         flush,
  // fill side
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // drain side
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(D);
  logic [W-1:0] store [D];
  logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0]   count, next_count;
  logic          doPush, doPop;

  assign inReady  = (count != D[AW:0]);
  assign outValid = (count != '0);
  assign outData  = store[rdPtr];

  always_comb begin
    doPush     = inValid && inReady && !flush;
    doPop      = outValid && outReady && !flush;
    next_wrPtr = doPush ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = doPop ? rdPtr + 1'b1 : rdPtr;
    next_count = count + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};
    if (flush) begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_count = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      store[wrPtr] <= inData;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module psb_core (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // memory bus pins
  input  wire logic              chipSelectN,
  input  wire logic              addressValidN,
  input  wire logic              writeEnableN,
  input  wire logic [1:0]        byteLaneSelectsN,
  input  wire logic [19:0]       memAddr,
  input  wire psb_pkg::psb_word_t dqIn,
  output psb_pkg::psb_word_t     dqOut,
  output logic                   dqOe,
  output logic                   waitN,
  // register port
  input  wire logic [3:0]        regAddr,
  input  wire logic [15:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [15:0]            regRdata
);
  import psb_pkg::*;

  psb_word_t  mem [1 << `PSB_MEM_AW];
  psb_state_t state, next_state;
  logic [15:0] busConfigReg, next_busConfigReg, next_regRdata;
  logic [3:0]  stat, next_stat;
  logic [11:0] initCnt, next_initCnt;
  logic [7:0]  selLowCnt, next_selLowCnt, weLowCnt, next_weLowCnt;
  logic [19:0] burstAddr, next_burstAddr, fetchAddr, next_fetchAddr;
  logic [3:0]  lat, next_lat, rowCnt, next_rowCnt;
  logic        isWrite, next_isWrite, sor, next_sor;
  logic        next_waitN, next_dqOe;
  psb_word_t   next_dqOut, wrWord, fifoData;
  logic        memWe, abortNow, initDone;
  logic [19:0] memWrAddr;
  logic [2:0]  lc;
  logic [3:0]  rowWaitLen;
  logic        fifoInReady, fifoOutValid, fifoPop, fifoFlush, fetchOn;

  assign initDone = stat[`PSB_STAT_INIT];
  assign lc       = busConfigReg[`PSB_CFG_LC_HI:`PSB_CFG_LC_LO];
  // writes wait one code, reads two; never less than a single clock
  assign rowWaitLen = (lc == 3'h0) ? 4'h1 :
                      isWrite ? {1'b0, lc} : {lc, 1'b0};

  // read prefetch: fills during latency and row waits, stalls when full
  assign fetchOn   = (state != PSB_IDLE) && !isWrite;
  assign fifoFlush = (state == PSB_IDLE);
  psb_fifo #(.W(16), .D(`PSB_FIFO_DEPTH)) u_fifo (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .flush    (fifoFlush),
    .inValid  (fetchOn),
    .inReady  (fifoInReady),
    .inData   (mem[fetchAddr[`PSB_MEM_AW-1:0]]),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state     = state;
    next_burstAddr = burstAddr;
    next_fetchAddr = (fetchOn && fifoInReady) ? fetchAddr + 20'h1 : fetchAddr;
    next_lat       = lat;
    next_rowCnt    = rowCnt;
    next_isWrite   = isWrite;
    next_sor       = sor;
    next_dqOe      = 1'b0;
    next_dqOut     = dqOut;
    memWe          = 1'b0;
    memWrAddr      = memAddr;
    abortNow       = 1'b0;
    fifoPop        = 1'b0;
    case (state)
      PSB_IDLE: begin
        if (initDone && !chipSelectN) begin
          if (!busConfigReg[`PSB_CFG_ASYNC] && !addressValidN) begin
            next_state     = PSB_LAT;
            next_burstAddr = memAddr;
            next_fetchAddr = memAddr;
            next_isWrite   = !writeEnableN;
            next_lat       = {1'b0, lc};
            next_sor       = 1'b0;
          end else if (busConfigReg[`PSB_CFG_ASYNC] && !writeEnableN) begin
            memWe = 1'b1;
          end else if (busConfigReg[`PSB_CFG_ASYNC]) begin
            next_dqOut = mem[memAddr[`PSB_MEM_AW-1:0]];
            next_dqOe  = 1'b1;
          end
        end
      end
      PSB_LAT: begin
        if (chipSelectN) begin
          next_state = PSB_IDLE;
        end else if (lat == 4'h0) begin
          next_state = PSB_DATA;
        end else begin
          next_lat = lat - 4'h1;
        end
      end
      PSB_DATA: begin
        if (sor && isWrite && (chipSelectN || !addressValidN)) begin
          abortNow   = 1'b1;
          next_state = PSB_IDLE;
        end else if (chipSelectN) begin
          next_state = PSB_IDLE;
        end else if (isWrite || fifoOutValid) begin
          memWe     = isWrite;
          memWrAddr = burstAddr;
          fifoPop   = !isWrite;
          if (!isWrite) begin
            next_dqOut = fifoData;
            next_dqOe  = 1'b1;
          end
          next_burstAddr = burstAddr + 20'h1;
          next_sor       = 1'b0;
          if (&burstAddr[`PSB_ROW_AW-1:0]) begin
            next_state  = PSB_ROWWAIT;
            next_rowCnt = rowWaitLen - 4'h1;
          end
        end
      end
      PSB_ROWWAIT: begin
        if (chipSelectN) begin
          next_state = PSB_IDLE;
        end else if (rowCnt == 4'h0) begin
          next_state = PSB_DATA;
          next_sor   = 1'b1;
        end else begin
          next_rowCnt = rowCnt - 4'h1;
        end
      end
      default: next_state = PSB_IDLE;
    endcase
    // wait tracks the state we enter; read data gaps also hold it
    next_waitN = !((next_state == PSB_LAT) || (next_state == PSB_ROWWAIT) ||
                   (next_state == PSB_DATA && !isWrite && !fifoOutValid &&
                    state == PSB_DATA));
    wrWord = mem[memWrAddr[`PSB_MEM_AW-1:0]];
    if (!byteLaneSelectsN[0]) wrWord[7:0] = dqIn[7:0];
    if (!byteLaneSelectsN[1]) wrWord[15:8] = dqIn[15:8];
  end

  // monitors of the host's duties and the register port
  always_comb begin
    next_initCnt      = initDone ? initCnt : initCnt + 12'h1;
    next_stat         = stat;
    next_busConfigReg = busConfigReg;
    next_regRdata     = 16'h0000;
    // a clocked select-high is a refresh opportunity
    next_selLowCnt = chipSelectN ? 8'h00 : selLowCnt + 8'h1;
    next_weLowCnt  = writeEnableN ? 8'h00 : weLowCnt + 8'h1;
    if (regWr && regAddr == `PSB_REG_CFG) begin
      next_busConfigReg = regWdata;
    end
    if (regWr && regAddr == `PSB_REG_STAT) begin
      next_stat[3:1] = stat[3:1] & ~regWdata[3:1];
    end
    if (initCnt == 12'(`PSB_PU_CYC - 1)) begin
      next_stat[`PSB_STAT_INIT] = 1'b1;
    end
    if (selLowCnt == 8'(`PSB_CEM_CYC) && !busConfigReg[`PSB_CFG_ASYNC]) begin
      next_stat[`PSB_STAT_REFOVR] = 1'b1;
    end
    if (weLowCnt == 8'(`PSB_CEM_CYC)) begin
      next_stat[`PSB_STAT_WELONG] = 1'b1;
    end
    if (abortNow) begin
      next_stat[`PSB_STAT_ABORT] = 1'b1;
    end
    if (regRd && regAddr == `PSB_REG_CFG) next_regRdata = busConfigReg;
    if (regRd && regAddr == `PSB_REG_STAT) next_regRdata = {12'h000, stat};
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state        <= PSB_IDLE;
      burstAddr    <= 20'h00000;
      fetchAddr    <= 20'h00000;
      lat          <= 4'h0;
      rowCnt       <= 4'h0;
      isWrite      <= 1'b0;
      sor          <= 1'b0;
      dqOut        <= 16'h0000;
      dqOe         <= 1'b0;
      waitN        <= 1'b1;
      busConfigReg <= `PSB_CFG_RESET;
      stat         <= 4'h0;
      initCnt      <= 12'h000;
      selLowCnt    <= 8'h00;
      weLowCnt     <= 8'h00;
      regRdata     <= 16'h0000;
    end else begin
      state        <= next_state;
      burstAddr    <= next_burstAddr;
      fetchAddr    <= next_fetchAddr;
      lat          <= next_lat;
      rowCnt       <= next_rowCnt;
      isWrite      <= next_isWrite;
      sor          <= next_sor;
      dqOut        <= next_dqOut;
      dqOe         <= next_dqOe;
      waitN        <= next_waitN;
      busConfigReg <= next_busConfigReg;
      stat         <= next_stat;
      initCnt      <= next_initCnt;
      selLowCnt    <= next_selLowCnt;
      weLowCnt     <= next_weLowCnt;
      regRdata     <= next_regRdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (memWe) begin
      mem[memWrAddr[`PSB_MEM_AW-1:0]] <= wrWord;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper: length of the current row-crossing wait
  logic [4:0] waitRun;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      waitRun <= 5'h00;
    end else begin
      waitRun <= (state == PSB_ROWWAIT) ? waitRun + 5'h1 : 5'h00;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_refresh_op;
    chipSelectN |=> (selLowCnt == 8'h00);
  endproperty
  a_refresh_op: assert property (p_refresh_op)
    else $error("clocked select high did not restart select-low count");

  property p_read_row_wait;
    (state == PSB_ROWWAIT && !isWrite && lc != 3'h0)
      |-> (waitRun < {1'b0, lc, 1'b0});
  endproperty
  a_read_row_wait: assert property (p_read_row_wait)
    else $error("read row wait exceeded twice the latency code");

  property p_latency;
    (state == PSB_IDLE) ##1 (state == PSB_LAT) |-> (lat == {1'b0, lc});
  endproperty
  a_latency: assert property (p_latency)
    else $error("latency count not loaded from config code");

  property p_write_row_wait;
    (state == PSB_ROWWAIT && isWrite && !chipSelectN && lc != 3'h0)
      ##1 (state == PSB_DATA)
      |-> ($past(waitRun) + 5'h1 >= {2'b00, lc}) &&
          ($past(waitRun) + 5'h1 <= {1'b0, lc, 1'b0});
  endproperty
  a_write_row_wait: assert property (p_write_row_wait)
    else $error("write row wait outside one to two latency codes");

  property p_sor_abort;
    (state == PSB_DATA && sor && isWrite && !addressValidN)
      |-> !memWe ##1 (state == PSB_IDLE) && stat[`PSB_STAT_ABORT];
  endproperty
  a_sor_abort: assert property (p_sor_abort)
    else $error("start-of-row abort wrote data or kept bursting");

  c_read_burst: cover property (state == PSB_DATA && !isWrite ##1 dqOe);
  c_row_cross: cover property (state == PSB_ROWWAIT ##1 state == PSB_DATA);
  c_abort: cover property (abortNow);
endmodule

/* sim/psb_host_model.sv */
// Purpose: host memory controller driving the memory bus pins
// Assumes: tasks are entered just after a rising edge of ref_clk
// Notes:   released address and data lines toggle, never hold old values
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module psb_host_model (
  // clock and device outputs
  input  wire logic               ref_clk,
  input  wire psb_pkg::psb_word_t dqOut,
  input  wire logic               dqOe,
  input  wire logic               waitN,
  // bus pins to device
  output logic                    chipSelectN,
  output logic                    addressValidN,
  output logic                    writeEnableN,
  output logic [1:0]              byteLaneSelectsN,
  output logic [19:0]             memAddr,
  output psb_pkg::psb_word_t      dqIn
);
  import psb_pkg::*;
  psb_word_t got[$];
  int        waitRuns[$];
  int        lowRun = 0;
  bit        drv = 1'b0;

  initial begin
    chipSelectN = 1'b1;
    addressValidN = 1'b1;
    writeEnableN = 1'b1;
    byteLaneSelectsN = 2'b00;
    memAddr = 20'h00000;
    dqIn = 16'h0000;
  end

  // idle lines are not left parked on their last value
  always @(posedge ref_clk) begin
    if (!drv) begin
      memAddr <= ~memAddr;
      dqIn <= ~dqIn;
    end
    if (dqOe === 1'b1) got.push_back(dqOut);
    if (!chipSelectN && waitN === 1'b0) lowRun++;
    else if (lowRun > 0) begin
      waitRuns.push_back(lowRun);
      lowRun = 0;
    end
  end

  // clocked deselect doubles as refresh opportunity and gap
  task automatic gap(input int n);
    chipSelectN <= 1'b1;
    addressValidN <= 1'b1;
    writeEnableN <= 1'b1;
    drv = 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic asyncAcc(input logic [19:0] a, input logic wr,
                          input logic [1:0] lanes, input psb_word_t d,
                          input int n);
    got.delete();
    drv = 1'b1;
    chipSelectN <= 1'b0;
    writeEnableN <= !wr;
    byteLaneSelectsN <= lanes;
    memAddr <= a;
    dqIn <= d;
    repeat (n) @(posedge ref_clk);
    gap(2);
  endtask

  // select held past first word; burst length n is not limited to the cap
  task automatic burst(input logic [19:0] a, input logic wr, input int n,
                       input logic abort);
    bit cut = 1'b0;
    got.delete();
    waitRuns.delete();
    drv = 1'b1;
    chipSelectN <= 1'b0;
    addressValidN <= 1'b0;
    writeEnableN <= !wr;
    byteLaneSelectsN <= 2'b00;
    memAddr <= a;
    dqIn <= 16'hBEEF;
    @(posedge ref_clk);
    addressValidN <= 1'b1;
    for (int i = 1; i < n && !cut; i++) begin
      @(posedge ref_clk);
      #1;
      addressValidN <= !(abort && (waitRuns.size() + (lowRun > 0)) > 1);
      cut = abort && (waitRuns.size() > 1);
    end
    // after an abort, deselect at once so idle does not start a new burst
    if (!cut) @(posedge ref_clk);
    gap(2);
  endtask
endmodule

/* sim/tb_psb_core.sv */
// Purpose: self-checking bench of the memory bus front end
// Assumes: host model drives the pins, bench drives the register port
// Notes:   status values are compared as whole words
`timescale 1ns/1ps
`include "psb_defines.svh"

////////////////////////////////////////////////////////////////////////////
module tb_psb_core;
  import psb_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] regRdata;
  logic        chipSelectN, addressValidN, writeEnableN, dqOe, waitN;
  logic [1:0]  byteLaneSelectsN;
  logic [19:0] memAddr;
  psb_word_t   dqIn, dqOut;
  int          failures = 0;
  int          checks = 0;
  int          cycles = 0;

  always #25 ref_clk = ~ref_clk;

  psb_core psb_core_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .chipSelectN(chipSelectN), .addressValidN(addressValidN),
    .writeEnableN(writeEnableN), .byteLaneSelectsN(byteLaneSelectsN),
    .memAddr(memAddr), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
    .waitN(waitN), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

  psb_host_model psb_host_model_i (.ref_clk(ref_clk), .dqOut(dqOut),
    .dqOe(dqOe), .waitN(waitN), .chipSelectN(chipSelectN),
    .addressValidN(addressValidN), .writeEnableN(writeEnableN),
    .byteLaneSelectsN(byteLaneSelectsN), .memAddr(memAddr), .dqIn(dqIn));

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      test_done();
    end
  end

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic regW(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rc(input string n, input logic [3:0] a,
                    input logic [15:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk(n, e, regRdata);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rc("config reset", `PSB_REG_CFG, `PSB_CFG_RESET);
    rc("status reset", `PSB_REG_STAT, 16'h0000);
    regW(4'h8, 16'hFFFF);
    rc("unmapped", 4'h8, 16'h0000);
    psb_host_model_i.asyncAcc(20'h5, 1'b0, 2'b00, 16'h0000, 2);
    chk("early read", 16'h0000, psb_host_model_i.got.size());
    repeat (2974) @(posedge ref_clk);
    rc("init pending", `PSB_REG_STAT, 16'h0000);
    repeat (20) @(posedge ref_clk);
    rc("init done", `PSB_REG_STAT, 16'h0001);
    $display("test reset and init done");
    psb_host_model_i.asyncAcc(20'h5, 1'b1, 2'b00, 16'h1234, 2);
    psb_host_model_i.asyncAcc(20'h5, 1'b1, 2'b10, 16'hFFAB, 2);
    psb_host_model_i.asyncAcc(20'h5, 1'b0, 2'b00, 16'h0000, 2);
    chk("lane read", 16'h12AB, psb_host_model_i.got[0]);
    for (int a = 'h7C; a < 'h82; a++)
      psb_host_model_i.asyncAcc(a[19:0], 1'b1, 2'b00, 16'h1000 + a[15:0], 2);
    psb_host_model_i.asyncAcc(20'h10, 1'b1, 2'b00, 16'h0000, 170);
    rc("we overrun", `PSB_REG_STAT, 16'h0005);
    regW(`PSB_REG_STAT, 16'h0004);
    rc("we cleared", `PSB_REG_STAT, 16'h0001);
    $display("test async done");
    regW(`PSB_REG_CFG, 16'h1000);
    rc("config sync", `PSB_REG_CFG, 16'h1000);
    psb_host_model_i.burst(20'h7C, 1'b0, 20, 1'b0);
    for (int k = 0; k < 6; k++)
      chk("burst word", 16'h107C + k[15:0], psb_host_model_i.got[k]);
    chk("latency wait", 16'h0003, psb_host_model_i.waitRuns[0]);
    chk("read row wait", 16'h0001,
        psb_host_model_i.waitRuns[1] inside {[1:4]});
    $display("test burst read done");
    psb_host_model_i.burst(20'h7F, 1'b1, 12, 1'b1);
    chk("write row wait", 16'h0001,
        psb_host_model_i.waitRuns[1] inside {[2:4]});
    rc("abort flagged", `PSB_REG_STAT, 16'h0009);
    regW(`PSB_REG_STAT, 16'h0008);
    psb_host_model_i.burst(20'h7F, 1'b0, 12, 1'b0);
    chk("burst write word", 16'hBEEF, psb_host_model_i.got[0]);
    chk("row start kept", 16'h1080, psb_host_model_i.got[1]);
    $display("test burst abort done");
    psb_host_model_i.burst(20'h0, 1'b0, 170, 1'b0);
    rc("select overrun", `PSB_REG_STAT, 16'h0003);
    regW(`PSB_REG_STAT, 16'h0002);
    psb_host_model_i.burst(20'h0, 1'b0, 100, 1'b0);
    psb_host_model_i.burst(20'h0, 1'b0, 100, 1'b0);
    rc("refresh given", `PSB_REG_STAT, 16'h0001);
    $display("test refresh done");
    test_done();
  end
endmodule
